// ### pkg/acs_defs.vh
// Constants for the converter output clock sync and coding block
// Operation
// - Sync reset may be asserted at any time, unrelated to the sample clock.
// - While sync reset is held, word clock parks at a level set by mode and edge.
// - Asserting sync reset may cut the word clock phase, one short pulse allowed.
// - First sample rising edge after release fixes the word clock phase.
// - Word clock restarts after the normal fixed clock-to-output latency, always same.
// - Plus zero and minus zero offset differ by a sixteenth of an LSB.
// - Output is offset binary: all zeros low end, all ones high end.
// - Over-range input clips at range end, out-of-range flag raised meanwhile.
// - Normal mode: full-scale pin low shrinks code voltages to 75 percent.
// - Extended mode: range and offset come from registers, pin ignored.
// - Each in-range sample becomes an unsigned 8-bit word.
// - Out-of-range flag is differential, positive high and negative low when active.
// - Calibration-active indicator stays high for the whole self-calibration run.
// - DDR gives a word on each clock edge; SDR only on the selected edge.
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

// ----------------------------------------------------------------
// Register map (Wishbone, byte addresses)
// ----------------------------------------------------------------
`define ACS_ADDR_CONFIG 4'h4
`define ACS_ADDR_OFFSET 4'h8
`define ACS_ADDR_FSADJ 4'hC
`define ACS_ADDR_STATUS 4'h0

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define ACS_CFG_EXT_BIT 0
`define ACS_CFG_SDR_BIT 1
`define ACS_CFG_EDGE_BIT 2
`define ACS_CFG_CAL_BIT 3
`define ACS_CFG_RESET 4'h0
`define ACS_OFS_SIGN_BIT 8
`define ACS_OFS_RESET 9'h000
`define ACS_FS_RESET 9'h100
`define ACS_FS_MID 9'h100

// ----------------------------------------------------------------
// Timing and coding
// ----------------------------------------------------------------
`define ACS_LATENCY 4'h3
`define ACS_CAL_CYCLES 16'h0400
`define ACS_CODE_MAX 8'hFF
`define ACS_CODE_MIN 8'h00
`define ACS_SIGN_ZERO_STEP 4'h1

`endif

// ### hdl/acs_sync2.v
// Two-flip-flop synchroniser for a level from outside the clock domain
module acs_sync2 (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Level
  input wire d_i,
  output reg q_o
);
  reg meta_reg;

  // First stage feeds only the second
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// ### hdl/acs_coder.v
// Sample coder: gain, offset, clipping to offset binary
`include "acs_defs.vh"
module acs_coder (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Sample and settings
  input wire signed [11:0] sample_i,
  input wire [8:0] gain_i,
  input wire [8:0] offset_i,
  // Result
  output reg [7:0] code_o,
  output reg over_o
);
  reg signed [23:0] scaled;
  reg signed [23:0] shifted;
  reg signed [23:0] biased;

  // Scale, add signed offset in quarter-LSB steps at sixteenth-LSB resolution, then clip
  always @* begin
    scaled = sample_i * $signed({1'b0, gain_i});
    shifted = scaled >>> 8;
    // Sixteenth-LSB resolution keeps minus zero apart from plus zero
    if (offset_i[`ACS_OFS_SIGN_BIT]) begin
      biased = shifted * 24'sd16 - $signed({16'h0000, offset_i[7:0]}) * 24'sd4
        - $signed({20'h00000, `ACS_SIGN_ZERO_STEP}) + 24'sd2048;
    end else begin
      biased = shifted * 24'sd16 + $signed({16'h0000, offset_i[7:0]}) * 24'sd4 + 24'sd2048;
    end
  end

  // Register result with clipping; flag follows excursion
  always @(posedge clk_i) begin
    if (rst_i) begin
      code_o <= 8'h80;
      over_o <= 1'b0;
    end else if (biased < 0) begin
      code_o <= `ACS_CODE_MIN;
      over_o <= 1'b1;
    end else if (biased > 24'sd4095) begin
      code_o <= `ACS_CODE_MAX;
      over_o <= 1'b1;
    end else begin
      code_o <= biased[11:4];
      over_o <= 1'b0;
    end
  end
endmodule

// ### hdl/acs_top.v
// Output word clock alignment, sample coding and control registers
`include "acs_defs.vh"
module acs_top (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Pins
  input wire output_clock_sync_reset_i,
  input wire full_scale_select_i,
  input wire output_edge_select_i,
  input wire sdr_select_i,
  input wire calibrate_i,
  input wire signed [11:0] sample_i,
  // Outputs
  output reg output_word_clock_o,
  output reg [7:0] data_o,
  output reg data_valid_o,
  output reg out_of_range_p_o,
  output reg out_of_range_n_o,
  output reg calibration_active_o
);
  // ----------------------------------------------------------------
  // Registers and synchronised pins
  // ----------------------------------------------------------------
  reg [3:0] cfg_reg;
  reg [8:0] offset_reg;
  reg [8:0] fs_reg;
  reg [15:0] cal_cnt_reg;
  reg cal_req_reg;
  reg [3:0] lat_reg;
  reg phase_reg;
  reg sync_d_reg;
  wire sync_s;
  wire fs_pin_s;
  wire edge_pin_s;
  wire sdr_pin_s;
  wire cal_pin_s;
  wire ext_mode;
  wire sdr_mode;
  wire edge_sel;
  reg [8:0] gain;
  reg [8:0] ofs;
  wire [7:0] code;
  wire over;
  wire wb_req;
  reg cal_pin_d_reg;

  // Control pins come from outside the domain: two flops each; sample_i goes to the coder unsynchronised
  acs_sync2 u_sync_rst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(output_clock_sync_reset_i),
    .q_o(sync_s)
  );
  acs_sync2 u_sync_fs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(full_scale_select_i),
    .q_o(fs_pin_s)
  );
  acs_sync2 u_sync_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(output_edge_select_i),
    .q_o(edge_pin_s)
  );
  acs_sync2 u_sync_sdr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(sdr_select_i),
    .q_o(sdr_pin_s)
  );
  acs_sync2 u_sync_cal (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(calibrate_i),
    .q_o(cal_pin_s)
  );

  // Mode selection: extended mode takes register settings over pins
  assign ext_mode = cfg_reg[`ACS_CFG_EXT_BIT];
  assign sdr_mode = ext_mode ? cfg_reg[`ACS_CFG_SDR_BIT] : sdr_pin_s;
  assign edge_sel = ext_mode ? cfg_reg[`ACS_CFG_EDGE_BIT] : edge_pin_s;

  // Gain and offset source
  always @* begin
    if (ext_mode) begin
      gain = fs_reg;
      ofs = offset_reg;
    end else begin
      // 75 percent of mid gain for pin low
      gain = fs_pin_s ? `ACS_FS_MID : 9'h0C0;
      ofs = `ACS_OFS_RESET;
    end
  end

  // ----------------------------------------------------------------
  // Sample coding
  // ----------------------------------------------------------------
  acs_coder u_coder (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sample_i(sample_i),
    .gain_i(gain),
    .offset_i(ofs),
    .code_o(code),
    .over_o(over)
  );

  // ----------------------------------------------------------------
  // Word clock: divide by two, park while sync held, fixed restart latency
  // ----------------------------------------------------------------
  // The pin is async, so the held level appears two cycles late; a short
  // pulse may result when the park level differs from the running phase.
  always @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= 1'b0;
      lat_reg <= 4'h0;
      sync_d_reg <= 1'b0;
      output_word_clock_o <= 1'b0;
    end else begin
      sync_d_reg <= sync_s;
      if (sync_s) begin
        // Park level: DDR parks low; SDR parks opposite the launch edge
        output_word_clock_o <= sdr_mode ? ~edge_sel : 1'b0;
        phase_reg <= 1'b0;
        lat_reg <= `ACS_LATENCY;
      end else if (lat_reg != 4'h0) begin
        // Hold parked for the same latency as normal data path
        lat_reg <= lat_reg - 4'h1;
      end else begin
        phase_reg <= ~phase_reg;
        // First toggle always leaves the park level, so words launch on the selected edge
        output_word_clock_o <= ~(phase_reg ^ (sdr_mode & ~edge_sel));
      end
    end
  end

  // Data launch: every clock edge in DDR, selected edge only in SDR
  always @(posedge clk_i) begin
    if (rst_i) begin
      data_o <= 8'h80;
      data_valid_o <= 1'b0;
      out_of_range_p_o <= 1'b0;
      out_of_range_n_o <= 1'b1;
    end else begin
      out_of_range_p_o <= over;
      out_of_range_n_o <= ~over;
      if (!sync_s && lat_reg == 4'h0 && (!sdr_mode || !phase_reg)) begin
        data_o <= code;
        data_valid_o <= 1'b1;
      end else begin
        data_valid_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Self-calibration run
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      cal_cnt_reg <= `ACS_CAL_CYCLES;
      calibration_active_o <= 1'b1;
      cal_pin_d_reg <= 1'b0;
    end else begin
      cal_pin_d_reg <= cal_pin_s;
      if ((cal_pin_s && !cal_pin_d_reg) || cal_req_reg) begin
        cal_cnt_reg <= `ACS_CAL_CYCLES;
        calibration_active_o <= 1'b1;
      end else if (cal_cnt_reg != 16'h0000) begin
        cal_cnt_reg <= cal_cnt_reg - 16'h0001;
        calibration_active_o <= 1'b1;
      end else begin
        calibration_active_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave: one wait state, ack for one cycle
  // ----------------------------------------------------------------
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= `ACS_CFG_RESET;
      offset_reg <= `ACS_OFS_RESET;
      fs_reg <= `ACS_FS_RESET;
      cal_req_reg <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      cal_req_reg <= 1'b0;
      wb_dat_o <= 32'h00000000;
      if (wb_req && wb_we_i) begin
        // Writes take effect on the edge that raises ack
        case (wb_adr_i)
          `ACS_ADDR_CONFIG: begin
            if (wb_sel_i[0]) begin
              cfg_reg <= {1'b0, wb_dat_i[2:0]};
              cal_req_reg <= wb_dat_i[`ACS_CFG_CAL_BIT];
            end
          end
          `ACS_ADDR_OFFSET: begin
            if (wb_sel_i[0]) begin
              offset_reg[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
              offset_reg[8] <= wb_dat_i[8];
            end
          end
          `ACS_ADDR_FSADJ: begin
            if (wb_sel_i[0]) begin
              fs_reg[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
              fs_reg[8] <= wb_dat_i[8];
            end
          end
          default: begin
            cfg_reg <= cfg_reg;
          end
        endcase
      end else if (wb_req) begin
        // Unmapped addresses read zero
        case (wb_adr_i)
          `ACS_ADDR_STATUS: begin
            wb_dat_o <= {28'h0000000, sync_s, sdr_mode, data_o[7], calibration_active_o};
          end
          `ACS_ADDR_CONFIG: begin
            wb_dat_o <= {28'h0000000, cfg_reg};
          end
          `ACS_ADDR_OFFSET: begin
            wb_dat_o <= {23'h000000, offset_reg};
          end
          `ACS_ADDR_FSADJ: begin
            wb_dat_o <= {23'h000000, fs_reg};
          end
          default: begin
            wb_dat_o <= 32'h00000000;
          end
        endcase
      end
    end
  end
endmodule

// ### test/acs_top_asserts.sv
// Port-level checks for the converter control top
module acs_top_asserts (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Observed ports
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire output_clock_sync_reset_i,
  input wire calibrate_i,
  input wire output_word_clock_o,
  input wire [7:0] data_o,
  input wire out_of_range_p_o,
  input wire out_of_range_n_o,
  input wire calibration_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // Sync hold and release steps
  // ----------------------------------------------------------------
  sequence release_s;
    $fell(output_clock_sync_reset_i) ##1 $stable(output_word_clock_o) [*3];
  endsequence
  sequence held_s;
    output_clock_sync_reset_i [*6];
  endsequence
  // Each checks one relation at the ports
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat not zero");
  or_diff_a: assert property (out_of_range_p_o != out_of_range_n_o) else $error("or legs");
  or_clip_a: assert property (out_of_range_p_o |-> data_o == 8'hFF || data_o == 8'h00)
    else $error("clip value");
  clk_park_a: assert property (held_s |-> $stable(output_word_clock_o)) else $error("no park");
  clk_restart_a: assert property (release_s |-> ##[1:6] $changed(output_word_clock_o))
    else $error("no restart");
  cal_run_a: assert property ($rose(calibrate_i) |-> ##[1:4] calibration_active_o)
    else $error("cal not started");
  cal_hold_a: assert property ($rose(calibration_active_o) |-> calibration_active_o [*8])
    else $error("cal dropped");
endmodule
bind acs_top acs_top_asserts acs_top_asserts_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .wb_dat_o, .output_clock_sync_reset_i, .calibrate_i, .output_word_clock_o,
  .data_o, .out_of_range_p_o, .out_of_range_n_o, .calibration_active_o);

// ### test/acs_sync_src.sv
// Controller model that issues the output clock sync pulse
module acs_sync_src (
  // Clocks
  input wire clk_i,
  input wire link_clk_i,
  // Control
  input wire req_i,
  input wire calibration_active_i,
  // Sync pulse
  output wire output_clock_sync_reset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic armed_reg = 1'b0;
  logic [3:0] cnt_reg = 4'h0;
  // Arming follows the link clock, so assertion is unrelated to clk_i
  always @(posedge link_clk_i) begin
    armed_reg <= req_i && !calibration_active_i;
  end
  // Width count saturates; release comes on a clk_i rise at saturation, or on a link_clk_i rise if arming drops
  always @(posedge clk_i) begin
    cnt_reg <= !armed_reg ? 4'h0 : (cnt_reg == 4'hF ? cnt_reg : cnt_reg + 4'h1);
  end
  assign output_clock_sync_reset_o = armed_reg && cnt_reg != 4'hF;
endmodule

// ### test/testbench.sv
// Self-checking bench for the converter control top
`include "acs_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, link_clk = 1'b0, req = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, output_clock_sync_reset_i, full_scale_select_i = 1'b1;
  logic output_edge_select_i = 1'b0, sdr_select_i = 1'b0, calibrate_i = 1'b0;
  logic signed [11:0] sample_i = 12'h000;
  logic output_word_clock_o, data_valid_o, out_of_range_p_o, out_of_range_n_o;
  logic calibration_active_o;
  logic [7:0] data_o;
  int bad_count = 0, num_checks = 0, n, k;
  int os[5] = '{0, 256, 16, 272, 511};
  int cs[6] = '{0, -128, 124, 128, -132, 2000};
  int gs[3] = '{256, 192, 128};
  always #12.5 clk_i = ~clk_i;
  initial #7 forever #100 link_clk = ~link_clk;
  acs_top acs_top_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .output_clock_sync_reset_i, .full_scale_select_i,
    .output_edge_select_i, .sdr_select_i, .calibrate_i, .sample_i, .output_word_clock_o,
    .data_o, .data_valid_o, .out_of_range_p_o, .out_of_range_n_o, .calibration_active_o);
  acs_sync_src acs_sync_src_i (.clk_i, .link_clk_i(link_clk), .req_i(req),
    .calibration_active_i(calibration_active_o),
    .output_clock_sync_reset_o(output_clock_sync_reset_i));
  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bounded wait for a level; a spent bound ends the run as a mismatch
  task automatic wait_for(ref logic s, input logic v);
    for (n = 0; s !== v; n++) begin
      if (n > 2000) begin
        bad_count++;
        tally_and_finish();
      end
      @(posedge clk_i);
    end
  endtask
  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, 4'hF, d};
    @(posedge clk_i);
    wait_for(wb_ack_o, 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  // Offset binary in sixteenths of an LSB, clipped: returns {out of range, code}
  // Offset steps a quarter LSB per code; minus zero sits one sixteenth below plus zero
  function automatic logic [8:0] exp_code(int s, int g, int o = 0);
    int v, m;
    m = o % 256 * 4;
    if (o >= 256) begin
      m = -m - int'(`ACS_SIGN_ZERO_STEP);
    end
    v = s * g / 256 * 16 + 2048 + m;
    return v < 0 ? 9'h100 : (v > 4095 ? 9'h1FF : {1'b0, 8'(v / 16)});
  endfunction
  task automatic run_s(int s, int g, int o = 0);
    @(posedge clk_i);
    sample_i <= 12'(s);
    repeat (4) @(posedge clk_i);
    #1;
    chk("data", data_o, exp_code(s, g, o) & 9'h0FF);
    chk("or", {out_of_range_p_o, out_of_range_n_o}, exp_code(s, g, o) >> 8 ? 2'b10 : 2'b01);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h9ECC36F2));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("rst", {output_word_clock_o, data_o, data_valid_o, out_of_range_p_o,
      out_of_range_n_o, calibration_active_o}, {1'b0, 8'h80, 4'b0011});
    wb(0, `ACS_ADDR_CONFIG, 0);
    chk("cfg", q, `ACS_CFG_RESET);
    wb(0, `ACS_ADDR_OFFSET, 0);
    chk("ofs", q, `ACS_OFS_RESET);
    wb(0, `ACS_ADDR_FSADJ, 0);
    chk("fs", q, `ACS_FS_RESET);
    wb(0, 4'h2, 0);
    chk("unmapped", q, 32'h0);
    wait_for(calibration_active_o, 1'b0);
    // Modes: pin high, pin low, extended with gain register and pin high but ignored
    for (int m = 0; m < 3; m++) begin
      @(posedge clk_i);
      full_scale_select_i <= m != 1;
      if (m == 2) begin
        wb(1, `ACS_ADDR_FSADJ, 32'h80);
        wb(1, `ACS_ADDR_CONFIG, 32'h1);
        wb(0, `ACS_ADDR_FSADJ, 0);
        chk("fs wr", q, 32'h80);
      end
      foreach (cs[i]) run_s(cs[i], gs[m]);
      repeat (10) run_s((int'($urandom % 151) - 75) * 4, gs[m]);
    end
    // Plus and minus zero, a step each way, and a clip, all in extended mode
    foreach (os[i]) begin
      wb(1, `ACS_ADDR_OFFSET, os[i]);
      run_s(0, 128, os[i]);
      run_s(cs[i], 128, os[i]);
    end
    wb(1, `ACS_ADDR_CONFIG, 32'h0);
    // Sync pulse in DDR and both SDR edges: park level then restart
    for (int m = 0; m < 3; m++) begin
      sdr_select_i <= m != 0;
      output_edge_select_i <= m == 2;
      req <= 1'b1;
      wait_for(output_clock_sync_reset_i, 1'b1);
      repeat (8) @(posedge clk_i);
      chk("park", output_word_clock_o, m == 1);
      wait_for(output_clock_sync_reset_i, 1'b0);
      req <= 1'b0;
      repeat (20) @(posedge clk_i);
      // DDR launches every cycle; SDR every other, on the selected word clock edge
      k = 0;
      repeat (8) begin
        @(posedge clk_i);
        k += data_valid_o;
        if (data_valid_o && m != 0) begin
          chk("edge", output_word_clock_o, m == 2);
        end
      end
      chk("valid", k, m == 0 ? 8 : 4);
    end
    // Commanded self-calibration
    calibrate_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("cal", calibration_active_o, 1'b1);
    calibrate_i <= 1'b0;
    wait_for(calibration_active_o, 1'b0);
    // Start bit in config is a pulse: status shows the run, config reads it back clear
    wb(1, `ACS_ADDR_CONFIG, 32'h8);
    wb(0, `ACS_ADDR_STATUS, 0);
    chk("status", q & 32'hD, 32'h5);
    wb(0, `ACS_ADDR_CONFIG, 0);
    chk("cfg cal", q, 32'h0);
    wait_for(calibration_active_o, 1'b0);
    tally_and_finish();
  end
endmodule
